// ---- rtl/adc_link_defs.svh ----
// Constants for the serial converter frame and power-mode control.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ADC_LINK_DEFS_SVH
`define ADC_LINK_DEFS_SVH

// ==========================================================
// Falling-edge thresholds within a frame
`define GLITCH_EDGE 5'd2
`define MODE_EDGE 5'd10
`define TRACK_EDGE 5'd13
`define WORD_EDGE 5'd16

// ==========================================================
// Result word layout
`define LEAD_ZEROS 5'd3
`define DATA_BITS 10
`define DATA_LAST_EDGE 5'd12

// ==========================================================
// Clock-domain crossing
`define SYNC_STAGES 2
`define SETTLE_CYCLES 2'd3

`endif

// ---- rtl/adc_link_pkg.sv ----
// Types and shared helpers for the frame and power-mode control.
// Assumes adc_link_defs.svh is on the include path.
`include "adc_link_defs.svh"

package adc_link_pkg;

	// ==========================================================
	// Types
	typedef logic [4:0] edge_count_t;
	typedef logic [`DATA_BITS-1:0] result_t;

	typedef enum logic [2:0] {
		ST_NORM_IDLE = 3'b000,
		ST_CONVERT = 3'b001,
		ST_SETTLE = 3'b011,
		ST_SHUT_IDLE = 3'b010,
		ST_WAKE = 3'b110
	} frame_state_e;

	// ==========================================================
	// Gray coding for the edge count crossing
	function automatic edge_count_t bin2gray(input edge_count_t b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic edge_count_t gray2bin(input edge_count_t g);
		edge_count_t b;
		b = g;
		for (int i = 3; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction

endpackage

// ---- rtl/bit_sync.sv ----
// Two-stage level synchroniser, one chain per bit.
// Assumes the input is quasi-static or gray coded across bits.
`timescale 1ns/10ps

module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	// ==========================================================
	// Synchroniser chain
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;

endmodule

// ---- rtl/adc_frame_control.sv ----
// Frame and power-mode control of a serial result converter.
// Assumes sclk and frame_select_n come from the host, conversion_result
// is held steady by the converter core around each frame start.
//
// How it works
// - Rise in edges ten to sixteen aborts.
// - Output floats after sixteen clock cycles.
// - Rise in edges two to ten: shutdown.
// - Rise before edge two keeps mode.
// - Frame from shutdown powers up, is dummy.
// - Waking frame cut early returns to shutdown.
// - Waking past edge ten becomes fully powered.
// - Power-on mode is a free choice.
// - Word: three zeros, ten bits, three zeros.
// - Select fall drives output; first clock fall samples input.
`timescale 1ns/10ps
`include "adc_link_defs.svh"

module adc_frame_control #(
	parameter logic START_SHUTDOWN = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire adc_link_pkg::result_t conversion_result,
	output logic serial_result_out,
	output logic serial_result_oe,
	output logic normal_mode,
	output logic analog_enable,
	output logic fully_powered,
	output logic result_dummy,
	output logic hold_request,
	output logic frame_aborted,
	output logic word_complete
);
	import adc_link_pkg::*;

	// ==========================================================
	// Link domain declarations
	logic started_reg;
	logic done_reg;
	logic data_out_reg;
	result_t result_hold_reg;
	edge_count_t count_reg;
	edge_count_t count_gray_reg;
	logic tag_reg;
	edge_count_t count_next;
	edge_count_t count_inc;
	logic data_next;

	// ==========================================================
	// Core domain declarations
	logic cs_sync;
	edge_count_t gray_sync;
	logic tag_sync;
	logic cs_prev_reg;
	logic tag_start_reg;
	logic from_shut_reg;
	logic dummy_pending_reg;
	logic [1:0] settle_reg;
	frame_state_e state_reg;
	frame_state_e state_next;
	logic normal_reg;
	logic analog_reg;
	logic powered_reg;
	logic dummy_reg;
	logic hold_reg;
	logic aborted_reg;
	logic complete_reg;
	logic cs_fall;
	logic cs_rise;
	logic settled;
	logic edges_moved;
	edge_count_t edges_seen;
	logic below_glitch;
	logic below_mode;
	logic below_word;
	logic go_shutdown;
	logic go_normal;

	// ==========================================================
	// Link domain: result bit for a given falling edge
	function automatic logic bit_for_edge(input edge_count_t n,
			input result_t w);
		edge_count_t idx;
		idx = `DATA_LAST_EDGE - n;
		bit_for_edge = 1'b0;
		if (n >= `LEAD_ZEROS && n <= `DATA_LAST_EDGE) begin
			bit_for_edge = w[idx[3:0]];
		end
	endfunction

	assign count_inc = (count_reg == `WORD_EDGE) ? count_reg
		: count_reg + 5'd1;
	// First falling edge of a frame restarts the count at one
	assign count_next = started_reg ? count_inc : 5'd1;
	assign data_next = (count_next == 5'd1) ? 1'b0
		: bit_for_edge(count_next, result_hold_reg);

	// ==========================================================
	// Link domain: frame-scoped flags, cleared by select high
	always_ff @(negedge sclk or posedge frame_select_n) begin
		if (frame_select_n) begin
			started_reg <= 1'b0;
			done_reg <= 1'b0;
			data_out_reg <= 1'b0;
		end else begin
			started_reg <= 1'b1;
			done_reg <= done_reg | (count_next == `WORD_EDGE);
			data_out_reg <= data_next;
		end
	end

	// ==========================================================
	// Link domain: edge count and frame tag
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			count_gray_reg <= '0;
			tag_reg <= 1'b0;
			result_hold_reg <= '0;
		end else if (!frame_select_n) begin
			count_reg <= count_next;
			count_gray_reg <= bin2gray(count_next);
			if (!started_reg) begin
				tag_reg <= ~tag_reg;
				result_hold_reg <= conversion_result;
			end
		end
	end

	// Line drives from select fall until word end or select rise
	assign serial_result_out = data_out_reg;
	assign serial_result_oe = ~frame_select_n & ~done_reg;

	// ==========================================================
	// Crossings into the core domain
	// Select synced as asserted-high so reset matches its idle level
	bit_sync #(.WIDTH(1)) cs_sync_u (
		.clk(mclk),
		.rst(rst),
		.d(~frame_select_n),
		.q(cs_sync)
	);

	bit_sync #(.WIDTH(5)) count_sync_u (
		.clk(mclk),
		.rst(rst),
		.d(count_gray_reg),
		.q(gray_sync)
	);

	bit_sync #(.WIDTH(1)) tag_sync_u (
		.clk(mclk),
		.rst(rst),
		.d(tag_reg),
		.q(tag_sync)
	);

	// ==========================================================
	// Core domain: frame edge detect and decision terms
	assign cs_fall = ~cs_prev_reg & cs_sync;
	assign cs_rise = cs_prev_reg & ~cs_sync;
	assign settled = (settle_reg == `SETTLE_CYCLES);
	// No clock edge in the frame leaves the tag unchanged
	assign edges_moved = (tag_sync != tag_start_reg);
	assign edges_seen = edges_moved ? gray2bin(gray_sync) : 5'd0;
	assign below_glitch = (edges_seen < `GLITCH_EDGE);
	assign below_mode = (edges_seen < `MODE_EDGE);
	assign below_word = (edges_seen < `WORD_EDGE);
	assign go_shutdown = settled & ~below_glitch & below_mode;
	assign go_normal = settled & ~below_mode;

	// ==========================================================
	// Core domain: next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_NORM_IDLE: begin
				if (cs_fall) begin
					state_next = ST_CONVERT;
				end
			end
			ST_SHUT_IDLE: begin
				if (cs_fall) begin
					state_next = ST_WAKE;
				end
			end
			ST_CONVERT, ST_WAKE: begin
				if (cs_rise) begin
					state_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settled) begin
					if (go_normal) begin
						state_next = ST_NORM_IDLE;
					end else if (go_shutdown) begin
						state_next = ST_SHUT_IDLE;
					end else begin
						state_next = from_shut_reg ? ST_SHUT_IDLE
							: ST_NORM_IDLE;
					end
				end
			end
			default: begin
				state_next = ST_SHUT_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Core domain: state, frame bookkeeping
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= START_SHUTDOWN ? ST_SHUT_IDLE
				: ST_NORM_IDLE;
			cs_prev_reg <= 1'b0;
			tag_start_reg <= 1'b0;
			from_shut_reg <= 1'b0;
			settle_reg <= '0;
		end else begin
			state_reg <= state_next;
			cs_prev_reg <= cs_sync;
			if (cs_fall) begin
				from_shut_reg <= (state_reg == ST_SHUT_IDLE);
			end
			// Rebase the tag at each decision, when it is stable
			if (settled) begin
				tag_start_reg <= tag_sync;
			end
			if (state_reg == ST_SETTLE && !settled) begin
				settle_reg <= settle_reg + 2'd1;
			end else begin
				settle_reg <= '0;
			end
		end
	end

	// ==========================================================
	// Core domain: power and dummy tracking
	always_ff @(posedge mclk) begin
		if (rst) begin
			dummy_pending_reg <= 1'b1;
			dummy_reg <= 1'b1;
			normal_reg <= ~START_SHUTDOWN;
			analog_reg <= ~START_SHUTDOWN;
			powered_reg <= 1'b0;
		end else begin
			if (cs_fall) begin
				dummy_reg <= dummy_pending_reg |
					(state_reg == ST_SHUT_IDLE);
				analog_reg <= 1'b1;
			end
			if (state_reg == ST_SETTLE && go_normal) begin
				normal_reg <= 1'b1;
				powered_reg <= 1'b1;
				dummy_pending_reg <= 1'b0;
			end else if (state_next == ST_SHUT_IDLE &&
					state_reg == ST_SETTLE) begin
				normal_reg <= 1'b0;
				analog_reg <= 1'b0;
				powered_reg <= 1'b0;
				dummy_pending_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Core domain: hold request and frame outcome pulses
	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_reg <= 1'b0;
			aborted_reg <= 1'b0;
			complete_reg <= 1'b0;
		end else begin
			if (cs_fall) begin
				hold_reg <= 1'b1;
			end else if (settled) begin
				hold_reg <= 1'b0;
			end
			aborted_reg <= settled & ~below_glitch & below_word;
			complete_reg <= settled & ~below_word;
		end
	end

	assign normal_mode = normal_reg;
	assign analog_enable = analog_reg;
	assign fully_powered = powered_reg;
	assign result_dummy = dummy_reg;
	assign hold_request = hold_reg;
	assign frame_aborted = aborted_reg;
	assign word_complete = complete_reg;

endmodule

// ---- dv/host_model.sv ----
// Host model: frames the link and collects the shifted result word.
// Assumes the bench calls frame() and that frames never overlap.
`timescale 1ns/10ps

module host_model (
	output logic sclk,
	output logic frame_select_n,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic last;

	initial begin
		sclk = 1'b1;
		frame_select_n = 1'b1;
		last = 1'b0;
	end

	// ==========================================================
	// One frame of n falling edges; the clock stands still outside it
	task automatic frame(input int n, output logic [14:0] w,
			output logic oe_end);
		w = '0;
		oe_end = 1'b1;
		frame_select_n = 1'b0;
		#30;
		for (int i = 1; i <= n; i++) begin
			#3 sclk = 1'b0;
			#3 sclk = 1'b1;
			// Released line shows the inverse of the last bit
			last = serial_result_oe ? serial_result_out : ~last;
			if (i <= 15) begin
				w = {w[13:0], last};
			end else if (i == 16) begin
				oe_end = serial_result_oe;
			end
		end
		#3 frame_select_n = 1'b1;
		#400;
	endtask
endmodule

// ---- dv/adc_frame_control_sva.sv ----
// Checker of the mode and status outputs of the frame control.
// Assumes it is bound to adc_frame_control and sees only its ports.
`timescale 1ns/10ps

module adc_frame_control_sva #(
	parameter logic START_SHUTDOWN = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire adc_link_pkg::result_t conversion_result,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic normal_mode,
	input wire logic analog_enable,
	input wire logic fully_powered,
	input wire logic result_dummy,
	input wire logic hold_request,
	input wire logic frame_aborted,
	input wire logic word_complete
);
	import adc_link_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Assertions
	oe_idle_a: assert property (frame_select_n |-> !serial_result_oe)
		else $error("output driven while select high");
	oe_start_a: assert property ($fell(frame_select_n) |-> serial_result_oe)
		else $error("output not driven at frame start");
	pulse_excl_a: assert property (!(frame_aborted && word_complete))
		else $error("abort and complete together");
	abort_one_a: assert property (frame_aborted |=> !frame_aborted)
		else $error("abort pulse longer than one cycle");
	abort_mode_a: assert property (frame_aborted |-> normal_mode == fully_powered)
		else $error("abort left wrong mode");
	shut_pwr_a: assert property (!analog_enable |-> !normal_mode && !fully_powered)
		else $error("shutdown with power flags set");
	wc_mode_a: assert property (word_complete |-> normal_mode && fully_powered)
		else $error("full word did not leave normal mode");
	pwr_rise_a: assert property ($rose(fully_powered) |-> word_complete || frame_aborted)
		else $error("power flag rose without decision");
	decide_hold_a: assert property ((frame_aborted || word_complete) |-> $past(hold_request, 3))
		else $error("decision without a held frame");
	dummy_fall_a: assert property ($fell(result_dummy) |-> normal_mode)
		else $error("dummy flag cleared outside normal mode");

	// ==========================================================
	// Covers
	cover property (word_complete);
	cover property (frame_aborted && !normal_mode);
	cover property (frame_aborted && normal_mode);
	cover property ($fell(result_dummy));
endmodule

bind adc_frame_control adc_frame_control_sva #(
	.START_SHUTDOWN(START_SHUTDOWN)
) u_sva (.mclk(mclk), .rst(rst), .sclk(sclk),
	.frame_select_n(frame_select_n), .conversion_result(conversion_result),
	.serial_result_out(serial_result_out),
	.serial_result_oe(serial_result_oe), .normal_mode(normal_mode),
	.analog_enable(analog_enable), .fully_powered(fully_powered),
	.result_dummy(result_dummy), .hold_request(hold_request),
	.frame_aborted(frame_aborted), .word_complete(word_complete));

// ---- dv/testbench.sv ----
// Self-checking bench of the frame and power-mode control.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module testbench;
	import adc_link_pkg::*;

	logic mclk, rst, sclk, frame_select_n;
	result_t conversion_result;
	logic serial_result_out, serial_result_oe, normal_mode, analog_enable;
	logic fully_powered, result_dummy, hold_request, frame_aborted;
	logic word_complete;
	int bad_count, n_checks;
	int n_ab = 0;
	int n_wc = 0;

	adc_frame_control u_dut (.mclk(mclk), .rst(rst), .sclk(sclk),
		.frame_select_n(frame_select_n),
		.conversion_result(conversion_result),
		.serial_result_out(serial_result_out),
		.serial_result_oe(serial_result_oe), .normal_mode(normal_mode),
		.analog_enable(analog_enable), .fully_powered(fully_powered),
		.result_dummy(result_dummy), .hold_request(hold_request),
		.frame_aborted(frame_aborted), .word_complete(word_complete));
	host_model u_host (.sclk(sclk), .frame_select_n(frame_select_n),
		.serial_result_out(serial_result_out),
		.serial_result_oe(serial_result_oe));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		n_ab <= n_ab + int'(frame_aborted === 1'b1);
		n_wc <= n_wc + int'(word_complete === 1'b1);
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic do_reset();
		@(negedge mclk) rst = 1'b1;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		check({normal_mode, analog_enable, fully_powered, result_dummy},
			4'b1101);
	endtask

	task automatic frame_chk(input int n, input result_t r, input logic m,
			input logic ab, input logic wc, input logic dm);
		logic [14:0] w;
		logic oe_end;
		int a0, w0;
		@(negedge mclk) conversion_result = r;
		a0 = n_ab;
		w0 = n_wc;
		u_host.frame(n, w, oe_end);
		check({normal_mode, analog_enable, result_dummy, hold_request},
			{m, m, dm, 1'b0});
		check(n_ab - a0, ab);
		check(n_wc - w0, wc);
		if (n >= 16) begin
			check(w, {2'b00, r, 3'b000});
			check(oe_end, 1'b0);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_full();
		frame_chk(16, 10'h2A5, 1'b1, 1'b0, 1'b1, 1'b1);
		frame_chk(16, 10'h35A, 1'b1, 1'b0, 1'b1, 1'b0);
		check(fully_powered, 1'b1);
	endtask

	task automatic t_abort();
		frame_chk(10, 10'h001, 1'b1, 1'b1, 1'b0, 1'b0);
		frame_chk(15, 10'h200, 1'b1, 1'b1, 1'b0, 1'b0);
		frame_chk(1, 10'h3FF, 1'b1, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_shut();
		int lens[2] = '{2, 9};
		foreach (lens[i]) begin
			frame_chk(lens[i], 10'h155, 1'b0, 1'b1, 1'b0, 1'b0);
			check(fully_powered, 1'b0);
			frame_chk(1, 10'h0F0, 1'b0, 1'b0, 1'b0, 1'b1);
			frame_chk(5, 10'h0F0, 1'b0, 1'b1, 1'b0, 1'b1);
			frame_chk(16, 10'h3C3, 1'b1, 1'b0, 1'b1, 1'b1);
			frame_chk(16, 10'h0C3, 1'b1, 1'b0, 1'b1, 1'b0);
		end
	endtask

	task automatic t_rerst();
		frame_chk(4, 10'h111, 1'b0, 1'b1, 1'b0, 1'b0);
		do_reset();
	endtask

	task automatic report_and_stop();
		$display("Checks made %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		conversion_result = '0;
		bad_count = 0;
		n_checks = 0;
		do_reset();
		t_full();
		t_abort();
		t_shut();
		t_rerst();
		report_and_stop();
	end

	initial begin
		#200us;
		bad_count++;
		report_and_stop();
	end
endmodule
